// >>> pkg/zsp_pkg.sv
// Shared constants and types for the zero-latency synchronous SRAM port.
package zsp_pkg;

    // ****************************************
    // Organisation
    // ****************************************
    // Narrow variant is 256K words of 18 bits, wide is 128K words of 36.
    localparam int NARROW_ADDR_W = 18;
    localparam int NARROW_DATA_W = 18;
    localparam int DEF_ADDR_W = 17;
    localparam int DEF_DATA_W = 36;
    // Each byte lane carries nine bits, parity bit included.
    localparam int LANE_W = 9;
    localparam int MAX_ADDR_W = 18;
    localparam int MAX_LANES = 4;

    // ****************************************
    // Burst counter
    // ****************************************
    localparam int BURST_W = 2;
    localparam logic [BURST_W-1:0] BURST_START = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
    // Burst order input level that selects the linear sequence.
    localparam logic BURST_LINEAR = 1'b0;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic RST_READ_VALID = 1'b0;
    localparam logic [BURST_W-1:0] RST_SEED = 2'h0;

    // Direction latched at the last load cycle.
    typedef enum logic [1:0] {
        ZSP_IDLE,
        ZSP_READ,
        ZSP_WRITE
    } zsp_cycle_e;

    // A write waiting one edge for its data.
    typedef struct packed {
        logic valid;
        logic [MAX_LANES-1:0] lane_n;
        logic [MAX_ADDR_W-1:0] addr;
    } zsp_write_s;

    localparam zsp_write_s RST_WRITE = '{
        valid: 1'b0,
        lane_n: 4'hF,
        addr: 18'h00000
    };

endpackage : zsp_pkg

// >>> logic/zsp_sram_port.sv
// Synchronous flow-through SRAM port with zero bus turnaround and bursts.
`timescale 1ns/1ns
// ****************************************
// Overview of operation
// - Array is 256Kx18 or 128Kx36 per build.
// - Reads and writes alternate with no waits.
// - All synchronous inputs taken on rising edge.
// - Advance/load low loads a new address.
// - Advance/load high steps counter, ignores direction.
// - Two-bit counter seeded from address low bits.
// - Direction decided only in load cycles.
// - Write is self-timed, no extra strobe.
// - Each lane enable gates its own lane.
// - Selected when both lows low, high high.
// - Chip selects sampled only when loading.
// - Clock hold freezes every register and the data output.
// - Output enable gates drivers asynchronously.
// - Sleep keeps contents and ignores other inputs.
// - Burst order low linear, high interleaved.
// - All lane enables low writes whole word.
// ****************************************
module zsp_sram_port
    import zsp_pkg::*;
#(
    parameter int ADDR_W = DEF_ADDR_W,
    parameter int DATA_W = DEF_DATA_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic read_write_in,
    input wire logic chip_select_n_in,
    input wire logic depth_select_n_in,
    input wire logic depth_select_in,
    input wire logic advance_or_load_n_in,
    input wire logic clock_hold_n_in,
    input wire logic [DATA_W/LANE_W-1:0] lane_write_n_in,
    input wire logic burst_mode_in,
    input wire logic sleep_request_in,
    input wire logic output_enable_n_in,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n_out
);

    // ****************************************
    // Sizes and storage
    // ****************************************
    localparam int LANES = DATA_W / LANE_W;
    localparam int DEPTH = 1 << ADDR_W;

    logic [DATA_W-1:0] mem [0:DEPTH-1];

    zsp_cycle_e cycle;
    logic [BURST_W-1:0] seed;
    logic [BURST_W-1:0] burst_cnt;
    logic [ADDR_W-BURST_W-1:0] base_upper;
    zsp_write_s pend;
    logic read_valid;

    // ****************************************
    // Helper functions
    // ****************************************
    // Low address bits for a burst position in either order.
    function automatic logic [BURST_W-1:0] burst_low(
        input logic [BURST_W-1:0] start,
        input logic [BURST_W-1:0] step,
        input logic mode
    );
        if (mode == BURST_LINEAR) begin
            return start + step;
        end
        return start ^ step;
    endfunction : burst_low

    // Keep old lanes where the lane enable is high.
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_word,
        input logic [DATA_W-1:0] new_word,
        input logic [LANES-1:0] lane_n
    );
        logic [DATA_W-1:0] result;
        result = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (!lane_n[i]) begin
                result[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
            end
        end
        return result;
    endfunction : lane_merge

    // ****************************************
    // Cycle decode
    // ****************************************
    // Sleep and clock hold both stop the edge; sleep also gates the pins.
    wire edge_live;
    wire load_cycle;
    wire chip_sel;
    wire [BURST_W-1:0] next_cnt;
    wire [BURST_W-1:0] next_seed;
    wire [ADDR_W-1:0] next_addr;
    zsp_cycle_e next_cycle;
    wire next_read;
    wire next_write;

    assign edge_live = ~clock_hold_n_in & ~sleep_request_in;
    assign load_cycle = ~advance_or_load_n_in;
    assign chip_sel = ~chip_select_n_in & ~depth_select_n_in
        & depth_select_in;
    assign next_cnt = load_cycle ? BURST_START : burst_cnt + BURST_STEP;
    assign next_seed = load_cycle ? addr_in[BURST_W-1:0] : seed;
    assign next_addr = load_cycle ? addr_in
        : {base_upper, burst_low(seed, next_cnt, burst_mode_in)};
    assign next_cycle = !load_cycle ? cycle
        : !chip_sel ? ZSP_IDLE
        : read_write_in ? ZSP_READ : ZSP_WRITE;
    assign next_read = (next_cycle == ZSP_READ);
    assign next_write = (next_cycle == ZSP_WRITE);

    // ****************************************
    // Write data path
    // ****************************************
    // A write's data arrives one edge after its address, so the word is
    // merged and stored then; a read of the same word in that cycle sees
    // the new data, which is what lets turnaround cost no cycle.
    wire write_now;
    wire [ADDR_W-1:0] pend_addr;
    wire [DATA_W-1:0] write_word;
    wire [DATA_W-1:0] read_word;

    assign write_now = pend.valid & edge_live;
    assign pend_addr = pend.addr[ADDR_W-1:0];
    assign write_word = lane_merge(mem[pend_addr], data_in,
        pend.lane_n[LANES-1:0]);
    assign read_word = (write_now && pend_addr == next_addr)
        ? write_word : mem[next_addr];

    // ****************************************
    // Array write
    // ****************************************
    // The array holds no reset so contents survive reset and sleep.
    // Self-timed write.
    always_ff @(posedge clk_in) begin
        if (write_now) begin
            mem[pend_addr] <= write_word;
        end
    end

    // ****************************************
    // Address and burst registers
    // ****************************************
    // Edge capture.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cycle <= ZSP_IDLE;
            seed <= RST_SEED;
            burst_cnt <= BURST_START;
            base_upper <= '0;
        end else if (edge_live) begin
            cycle <= next_cycle;
            seed <= next_seed;
            burst_cnt <= next_cnt;
            base_upper <= next_addr[ADDR_W-1:BURST_W];
        end
    end

    // ****************************************
    // Pending write capture
    // ****************************************
    // Enables with address.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pend <= RST_WRITE;
        end else if (edge_live) begin
            pend.valid <= next_write;
            pend.lane_n <= MAX_LANES'(lane_write_n_in);
            pend.addr <= MAX_ADDR_W'(next_addr);
        end
    end

    // ****************************************
    // Read data output
    // ****************************************
    // Read flows through.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            data_out <= '0;
            read_valid <= RST_READ_VALID;
        end else if (edge_live) begin
            read_valid <= next_read;
            if (next_read) begin
                data_out <= read_word;
            end
        end
    end

    // Drivers must answer the enable pin without a clock edge, so this
    // one output is a gate after the read-valid flip-flop.
    // Async output enable.
    assign data_oe_n_out = output_enable_n_in | ~read_valid
        | sleep_request_in;

endmodule : zsp_sram_port

// >>> verification/zsp_master.sv
// Bus master model that drives the SRAM port one cycle at a time.
`timescale 1ns/1ns
module zsp_master
    import zsp_pkg::*;
(
    input wire logic clk_in,
    input wire logic [DEF_DATA_W-1:0] data_in
);
    // ****
    // Pins
    // ****
    logic [DEF_ADDR_W-1:0] addr = '0;
    logic rw = 1'b1;
    logic cs_n = 1'b1;
    logic load_n = 1'b0;
    logic hold = 1'b0;
    logic oe_n = 1'b0;
    // Depth expansion selects start on and sleep starts off.
    logic depth_sel_n = 1'b0;
    logic depth_sel = 1'b1;
    logic sleep = 1'b0;
    // Burst order, static within a sequence.
    logic mode = BURST_LINEAR;
    logic [MAX_LANES-1:0] lane_n = 4'hF;
    logic [DEF_DATA_W-1:0] wd = '0;
    logic [DEF_DATA_W-1:0] q;
    // Pins move just after an edge; q is the previous cycle's answer.
    // Lane enables travel with their address.
    task automatic go(input logic l, r, c, h, input logic [16:0] a,
        input logic [3:0] b, input logic [35:0] d);
        @(posedge clk_in);
        load_n <= l;
        rw <= r;
        cs_n <= c;
        hold <= h;
        addr <= a;
        lane_n <= b;
        wd <= d;
        #1 q = data_in;
    endtask : go
    // Repeats the last command for one edge while the slow pins move,
    // so these pins also change only just after a rising edge.
    // Burst order moves only between sequences.
    task automatic side(input logic ds_n, ds, zz, oe, md);
        @(posedge clk_in);
        depth_sel_n <= ds_n;
        depth_sel <= ds;
        sleep <= zz;
        oe_n <= oe;
        mode <= md;
        #1 q = data_in;
    endtask : side
endmodule : zsp_master

// >>> verification/zsp_asserts.sv
// Concurrent checks on the SRAM port pins.
`timescale 1ns/1ns
module zsp_asserts
    import zsp_pkg::*;
#(
    parameter int DATA_W = DEF_DATA_W
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic read_write_in,
    input wire logic chip_select_n_in,
    input wire logic depth_select_n_in,
    input wire logic depth_select_in,
    input wire logic advance_or_load_n_in,
    input wire logic clock_hold_n_in,
    input wire logic sleep_request_in,
    input wire logic output_enable_n_in,
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_oe_n_out
);
    // Live edges, select decode and load cycles.
    wire logic live = !clock_hold_n_in && !sleep_request_in;
    wire logic sel = !chip_select_n_in && !depth_select_n_in
        && depth_select_in;
    wire logic load = live && !advance_or_load_n_in;
    wire logic quiet = output_enable_n_in || sleep_request_in;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_oe_gates_drv:
        assert property (output_enable_n_in |-> data_oe_n_out)
        else $error("drivers on with enable high");
    a_sleep_no_drv:
        assert property (sleep_request_in |-> data_oe_n_out)
        else $error("drivers on in sleep");
    a_hold_keeps_out:
        assert property (clock_hold_n_in |=> $stable(data_out))
        else $error("data moved on held edge");
    a_write_no_drv:
        assert property (load && sel && !read_write_in |=> data_oe_n_out)
        else $error("write cycle drove pins");
    a_read_flows_out:
        assert property (load && sel && read_write_in
            |=> quiet || !data_oe_n_out)
        else $error("read not driven");
    a_deselect_idle:
        assert property (load && !sel |=> data_oe_n_out)
        else $error("deselected load drove pins");
    a_adv_stays_idle:
        assert property (live && advance_or_load_n_in && data_oe_n_out
            && !quiet |=> data_oe_n_out)
        else $error("idle burst drove pins");
    a_adv_keeps_read:
        assert property (live && advance_or_load_n_in && !data_oe_n_out
            |=> quiet || !data_oe_n_out)
        else $error("read burst lost direction");
endmodule : zsp_asserts

// >>> verification/testbench.sv
// Self-checking bench for the SRAM port.
`timescale 1ns/1ns
module testbench
    import zsp_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    int failures = 0;
    int checks_done = 0;
    logic [DEF_DATA_W-1:0] pat = 36'h0A5A5A5A5;
    wire logic [DEF_DATA_W-1:0] data_out;
    wire logic data_oe_n_out;
    zsp_master m_u (.clk_in(clk_in), .data_in(data_out));
    zsp_sram_port dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .addr_in(m_u.addr), .read_write_in(m_u.rw),
        .chip_select_n_in(m_u.cs_n), .depth_select_n_in(m_u.depth_sel_n),
        .depth_select_in(m_u.depth_sel), .advance_or_load_n_in(m_u.load_n),
        .clock_hold_n_in(m_u.hold), .lane_write_n_in(m_u.lane_n),
        .burst_mode_in(m_u.mode), .sleep_request_in(m_u.sleep),
        .output_enable_n_in(m_u.oe_n), .data_in(m_u.wd),
        .data_out(data_out), .data_oe_n_out(data_oe_n_out));
    // Clock of 10 ns.
    initial forever #5 clk_in = ~clk_in;
    task automatic chk(input string n, input logic [35:0] e, g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // Watchdog; the whole sequence needs well under 100 cycles.
    initial begin
        repeat (2000) @(posedge clk_in);
        failures++;
        stop_test();
    end
    // Writes back to back, bursts, lanes, select and output enable.
    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            m_u.go(1'b0, i == 4, 1'b0, 1'b0, 17'(8 + i - (i == 4)),
                4'h0, pat + i - 1);
        end
        // Select and direction are ignored while advancing.
        for (int j = 0; j < 7; j++) begin
            m_u.go(1'b1, 1'b0, 1'b1, j == 5, 17'h0, 4'hF, pat);
            chk("linear", pat + ((3 + (j > 5 ? 5 : j)) & 3), m_u.q);
        end
        m_u.side(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h9, 4'hF, pat);
        for (int j = 0; j < 4; j++) begin
            m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h0, 4'hF, pat);
            chk("interleaved", pat + (1 ^ j), m_u.q);
        end
        m_u.go(1'b0, 1'b0, 1'b0, 1'b0, 17'h8, 4'hA, pat);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, ~36'h0);
        m_u.go(1'b1, 1'b0, 1'b0, 1'b0, 17'h0, 4'hF, pat);
        chk("lanes", pat | 36'h007FC01FF, m_u.q);
        m_u.go(1'b0, 1'b1, 1'b1, 1'b0, 17'h8, 4'hF, pat);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("deselect", 36'h1, data_oe_n_out);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("drive", 36'h0, data_oe_n_out);
        m_u.side(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        chk("oe", 36'h1, data_oe_n_out);
        // Second active-low select: ignored mid-burst, deselects a load.
        m_u.side(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("burst select", 36'h0, data_oe_n_out);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("second select", 36'h1, data_oe_n_out);
        // Active-high select low deselects too; all three on reselects.
        m_u.side(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("third select", 36'h1, data_oe_n_out);
        m_u.side(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        m_u.go(1'b0, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h8, 4'hF, pat);
        chk("reselect", pat | 36'h007FC01FF, m_u.q);
        // Sleep turns the drivers off at once and freezes the burst.
        m_u.side(1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        chk("sleep drive", 36'h1, data_oe_n_out);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h0, 4'hF, pat);
        chk("sleep hold", pat + 1, m_u.q);
        m_u.side(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        m_u.go(1'b1, 1'b1, 1'b0, 1'b0, 17'h0, 4'hF, pat);
        chk("wake", pat + 2, m_u.q);
        stop_test();
    end
endmodule : testbench
bind zsp_sram_port zsp_asserts #(.DATA_W(DATA_W)) asserts_u (.clk_in,
    .rst_in, .read_write_in, .chip_select_n_in, .depth_select_n_in,
    .depth_select_in, .advance_or_load_n_in, .clock_hold_n_in,
    .sleep_request_in, .output_enable_n_in, .data_out, .data_oe_n_out);
